/* rtl/ewt_pkg.sv */
// shared types, codes and timing for the two-wire eeprom target
package ewt_pkg;

   // protocol sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEV  = 3'b001,
      ST_WADR = 3'b010,
      ST_WDAT = 3'b011,
      ST_ACK  = 3'b100,
      ST_RD   = 3'b101,
      ST_RACK = 3'b110
   } ewt_state_t;

   // device address word as it arrives, msb first
   typedef struct packed {
      logic [3:0] nib;
      logic [2:0] cs;
      logic rd;
   } ewt_dev_word_t;

   // control nibbles
   localparam logic [3:0] NIB_ARRAY = 4'ha;
   localparam logic [3:0] NIB_EXT = 4'hb;
   localparam logic [3:0] NIB_WP = 4'h6;

   // array geometry
   localparam int PAGES = 16;
   localparam int PAGE_BYTES = 16;
   localparam int MEM_BYTES = PAGES * PAGE_BYTES;

   // extended block layout
   localparam logic [7:0] SERIAL_BASE = 8'h80;
   localparam logic [7:0] SERIAL_END = 8'h8f;
   localparam logic [7:0] EUI64_BASE = 8'h98;
   localparam logic [7:0] EUI48_BASE = 8'h9a;
   localparam logic [7:0] EXT_LAST = 8'h9f;
   localparam logic [7:0] EXT_BLANK = 8'hff;
   localparam logic [15:0] EXT_RSV_LO = 16'hfffe;

   // bit counter value after the eighth clock
   localparam logic [3:0] BIT_LAST = 4'h8;

   // self-timed write cycle
   localparam int T_WR_US = 5000;
   localparam int CLK_MHZ = 50;
   localparam int WR_CYCLES = T_WR_US * CLK_MHZ;
   localparam int WR_CNT_W = 18;

endpackage : ewt_pkg

/* rtl/ewt_eeprom_two_wire_target.sv */
// two-wire eeprom target: protocol front end, array, read-only id block
//
// How it works
// - main array is 16 pages of 16 bytes, 256 locations.
// - one 8-bit word address after the device word sets the pointer.
// - 48-bit id sits at 9Ah..9Fh, prefix low three, extension high three.
// - 64-bit id sits at 98h..9Fh, prefix then five extension bytes.
// - first two 64-bit extension bytes never equal FFFEh or FFFFh.
// - extended block is read-only, no transaction alters it.
// - start is data falling with clock high; every command starts so.
// - stop is data rising with clock high; stop after read gives standby.
// - eight-bit words, device pulls data low on ninth clock as ack.
// - standby after reset and after stop once internal work is done.
// - upper nibble 1010 selects array, 0110 selects protect write.
// - bits 3..1 must match the chip-select pins for an ack.
// - bit 0 high reads, low writes; mismatch returns to standby, no ack.
// - after protect programming, nibble 0110 is no longer acknowledged.
// - nibble 1011 selects extended block, chip-selects checked alike.
// - write cycle runs from the stop that ends a write until done.
// - during write cycle inputs are ignored, polling gets no ack.
// - write bursts bump only low four address bits, wrapping in page.
`timescale 1ns/100ps

module ewt_eeprom_two_wire_target #(
   parameter int WR_CYCLES = ewt_pkg::WR_CYCLES,
   parameter logic [127:0] SERIAL_NUM = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978,
   // arbitrary neutral organisation_prefix
   parameter logic [23:0] ORG_PREFIX = 24'h12_3456,
   parameter logic [23:0] EXT_ID_48 = 24'h00_0001,
   parameter logic [39:0] EXT_ID_64 = 40'h00_0000_0001,
   parameter bit EUI64 = 1'b0
) (
   // system side
   input wire logic clock,
   input wire logic rst,
   // link side
   input wire logic link_clk,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // hard-wired chip selects
   input wire logic chip_select_pin_2,
   input wire logic chip_select_pin_1,
   input wire logic chip_select_pin_0,
   // status
   output logic standby,
   output logic write_busy
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   localparam logic [ewt_pkg::WR_CNT_W-1:0] WR_LAST = ewt_pkg::WR_CNT_W'(WR_CYCLES - 1);
   // reserved pattern forced away by clearing the extension msb
   localparam logic [39:0] EXT40 = (EXT_ID_64[39:24] >= ewt_pkg::EXT_RSV_LO) ?
                                   {1'b0, EXT_ID_64[38:0]} : EXT_ID_64;
   localparam logic [63:0] EUI64_VAL = {ORG_PREFIX, EXT40};
   localparam logic [47:0] EUI48_VAL = {ORG_PREFIX, EXT_ID_48};

   logic rst_m_r, rst_link;
   logic [4:0] in1_r, in2_r;
   logic [1:0] in3_r;
   logic scl_s, sda_s, scl_d, sda_d;
   logic [2:0] cs_s;
   logic scl_rise, scl_fall, start, stop, byte_done;
   ewt_pkg::ewt_state_t state_r, after_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r, ptr_r, rd_byte;
   logic oe_r, rd_r, ext_r, wpc_r, cont_r;
   logic wr_pend_r, wpp_r, wp_prog_r, pend_r, req_t_r, standby_r;
   logic dn1_r, dn2_r, dn3_r, done_edge;
   logic rq1_r, rq2_r, rq3_r, busy_r, done_t_r;
   logic [ewt_pkg::WR_CNT_W-1:0] wcnt_r;
   logic mem_we, dev_ok;
   ewt_pkg::ewt_dev_word_t dw;
   logic [7:0] mem [0:ewt_pkg::MEM_BYTES-1];

   ////////////////////////////////////////////////////////////////////////////
   // read-only extended block contents
   function automatic logic [7:0] ext_byte(input logic [7:0] a);
      logic [7:0] off;
      logic [2:0] idx;
      ext_byte = ewt_pkg::EXT_BLANK;
      off = 8'h00;
      idx = 3'h0;
      if (a >= ewt_pkg::SERIAL_BASE && a <= ewt_pkg::SERIAL_END) begin
         off = a - ewt_pkg::SERIAL_BASE;
         ext_byte = SERIAL_NUM[{~off[3:0], 3'b000} +: 8];
      end else if (EUI64 && a >= ewt_pkg::EUI64_BASE && a <= ewt_pkg::EXT_LAST) begin
         off = a - ewt_pkg::EUI64_BASE;
         ext_byte = EUI64_VAL[{~off[2:0], 3'b000} +: 8];
      end else if (!EUI64 && a >= ewt_pkg::EUI48_BASE && a <= ewt_pkg::EXT_LAST) begin
         off = a - ewt_pkg::EUI48_BASE;
         idx = 3'(3'h5 - off[2:0]);
         ext_byte = EUI48_VAL[{idx, 3'b000} +: 8];
      end
   endfunction : ext_byte

   ////////////////////////////////////////////////////////////////////////////
   // link domain reset and pin synchronisers
   // reset crosses into the link clock so release is clean there
   always_ff @(posedge link_clk) begin
      rst_m_r <= rst;
      rst_link <= rst_m_r;
   end

   // scl, sda and chip selects: two flops, third stage only for edges
   always_ff @(posedge link_clk) begin
      if (rst_link) begin
         in1_r <= 5'h1f;
         in2_r <= 5'h1f;
         in3_r <= 2'h3;
      end else begin
         in1_r <= {scl, sda_i, chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
         in2_r <= in1_r;
         in3_r <= in2_r[4:3];
      end
   end

   assign scl_s = in2_r[4];
   assign sda_s = in2_r[3];
   assign cs_s = in2_r[2:0];
   assign scl_d = in3_r[1];
   assign sda_d = in3_r[0];
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   // data edges only count while clock stays high on both samples
   assign start = scl_s && scl_d && sda_d && !sda_s;
   assign stop = scl_s && scl_d && !sda_d && sda_s;
   assign byte_done = scl_fall && cnt_r == ewt_pkg::BIT_LAST;

   ////////////////////////////////////////////////////////////////////////////
   // device word decode
   assign dw = ewt_pkg::ewt_dev_word_t'(sh_r);
   // a pending write cycle blanks every address, polling included
   assign dev_ok = !pend_r && dw.cs == cs_s &&
                   (dw.nib == ewt_pkg::NIB_ARRAY || dw.nib == ewt_pkg::NIB_EXT ||
                    (dw.nib == ewt_pkg::NIB_WP && !dw.rd && !wp_prog_r));
   assign rd_byte = ext_r ? ext_byte(ptr_r) : mem[ptr_r];

   ////////////////////////////////////////////////////////////////////////////
   // protocol sequencer
   always_ff @(posedge link_clk) begin
      if (rst_link) begin
         state_r <= ewt_pkg::ST_IDLE;
         after_r <= ewt_pkg::ST_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         ptr_r <= 8'h00;
         oe_r <= 1'b0;
         rd_r <= 1'b0;
         ext_r <= 1'b0;
         wpc_r <= 1'b0;
         cont_r <= 1'b0;
         wr_pend_r <= 1'b0;
         wpp_r <= 1'b0;
         wp_prog_r <= 1'b0;
         pend_r <= 1'b0;
         req_t_r <= 1'b0;
      end else begin
         // clear first so a same-cycle set below wins
         if (done_edge) pend_r <= 1'b0;
         if (start) begin
            // repeated start also ends any half-done byte
            state_r <= ewt_pkg::ST_DEV;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
            ext_r <= 1'b0;
            wpc_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wpp_r <= 1'b0;
         end else if (stop) begin
            state_r <= ewt_pkg::ST_IDLE;
            oe_r <= 1'b0;
            if (wr_pend_r || wpp_r) begin
               req_t_r <= ~req_t_r;
               pend_r <= 1'b1;
            end
            if (wpp_r) wp_prog_r <= 1'b1;
            wr_pend_r <= 1'b0;
            wpp_r <= 1'b0;
         end else begin
            unique case (state_r)
               ewt_pkg::ST_IDLE: begin
                  oe_r <= 1'b0;
               end
               ewt_pkg::ST_DEV, ewt_pkg::ST_WADR, ewt_pkg::ST_WDAT: begin
                  if (scl_rise) begin
                     sh_r <= {sh_r[6:0], sda_s};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (byte_done) begin
                     cnt_r <= 4'h0;
                     if (state_r == ewt_pkg::ST_DEV) begin
                        if (dev_ok) begin
                           oe_r <= 1'b1;
                           state_r <= ewt_pkg::ST_ACK;
                           rd_r <= dw.rd;
                           ext_r <= dw.nib == ewt_pkg::NIB_EXT;
                           wpc_r <= dw.nib == ewt_pkg::NIB_WP;
                           after_r <= ewt_pkg::ST_WADR;
                        end else begin
                           state_r <= ewt_pkg::ST_IDLE;
                        end
                     end else if (state_r == ewt_pkg::ST_WADR) begin
                        ptr_r <= sh_r;
                        oe_r <= 1'b1;
                        state_r <= ewt_pkg::ST_ACK;
                        after_r <= ewt_pkg::ST_WDAT;
                     end else if (ext_r) begin
                        // only a dummy pointer load is legal here
                        state_r <= ewt_pkg::ST_IDLE;
                     end else begin
                        oe_r <= 1'b1;
                        state_r <= ewt_pkg::ST_ACK;
                        after_r <= ewt_pkg::ST_WDAT;
                        if (wpc_r) begin
                           wpp_r <= 1'b1;
                        end else begin
                           wr_pend_r <= 1'b1;
                           ptr_r <= {ptr_r[7:4], ptr_r[3:0] + 4'h1};
                        end
                     end
                  end
               end
               ewt_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     if (rd_r) begin
                        sh_r <= rd_byte;
                        oe_r <= ~rd_byte[7];
                        ptr_r <= ptr_r + 8'h01;
                        cnt_r <= 4'h0;
                        state_r <= ewt_pkg::ST_RD;
                     end else begin
                        oe_r <= 1'b0;
                        state_r <= after_r;
                     end
                  end
               end
               ewt_pkg::ST_RD: begin
                  if (scl_rise) begin
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall) begin
                     if (cnt_r == ewt_pkg::BIT_LAST) begin
                        oe_r <= 1'b0;
                        state_r <= ewt_pkg::ST_RACK;
                     end else begin
                        oe_r <= ~sh_r[3'(4'h7 - cnt_r)];
                     end
                  end
               end
               ewt_pkg::ST_RACK: begin
                  if (scl_rise) begin
                     cont_r <= !sda_s;
                  end else if (scl_fall) begin
                     if (cont_r) begin
                        sh_r <= rd_byte;
                        oe_r <= ~rd_byte[7];
                        ptr_r <= ptr_r + 8'h01;
                        cnt_r <= 4'h0;
                        state_r <= ewt_pkg::ST_RD;
                     end else begin
                        state_r <= ewt_pkg::ST_IDLE;
                     end
                  end
               end
               default: begin
                  state_r <= ewt_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // array store; the lower half is locked once protection is set
   assign mem_we = byte_done && state_r == ewt_pkg::ST_WDAT && !ext_r && !wpc_r &&
                   !(wp_prog_r && !ptr_r[7]) && !start && !stop;

   always_ff @(posedge link_clk) begin
      if (mem_we) mem[ptr_r] <= sh_r;
   end

   // open-drain output and standby flag
   always_ff @(posedge link_clk) begin
      if (rst_link) standby_r <= 1'b1;
      else standby_r <= state_r == ewt_pkg::ST_IDLE && !pend_r;
   end

   assign sda_o = 1'b0;
   assign sda_oe = oe_r;
   assign standby = standby_r;

   ////////////////////////////////////////////////////////////////////////////
   // write cycle timer on the system clock, toggle handshake both ways
   always_ff @(posedge link_clk) begin
      if (rst_link) begin
         dn1_r <= 1'b0;
         dn2_r <= 1'b0;
         dn3_r <= 1'b0;
      end else begin
         dn1_r <= done_t_r;
         dn2_r <= dn1_r;
         dn3_r <= dn2_r;
      end
   end

   assign done_edge = dn2_r ^ dn3_r;

   // counts whole write time even when protection dropped the data
   always_ff @(posedge clock) begin
      if (rst) begin
         rq1_r <= 1'b0;
         rq2_r <= 1'b0;
         rq3_r <= 1'b0;
         busy_r <= 1'b0;
         wcnt_r <= '0;
         done_t_r <= 1'b0;
      end else begin
         rq1_r <= req_t_r;
         rq2_r <= rq1_r;
         rq3_r <= rq2_r;
         if (rq2_r ^ rq3_r) begin
            busy_r <= 1'b1;
            wcnt_r <= '0;
         end else if (busy_r) begin
            if (wcnt_r == WR_LAST) begin
               busy_r <= 1'b0;
               done_t_r <= ~done_t_r;
            end else begin
               wcnt_r <= wcnt_r + 1'b1;
            end
         end
      end
   end

   assign write_busy = busy_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_start_dev: assert property (@(posedge link_clk) disable iff (rst_link)
      start |=> state_r == ewt_pkg::ST_DEV && !oe_r) else $error("start not taken");
   chk_stop_idle: assert property (@(posedge link_clk) disable iff (rst_link)
      stop |=> state_r == ewt_pkg::ST_IDLE ##1 (standby_r == !pend_r))
      else $error("stop did not idle");
   chk_ack_drive: assert property (@(posedge link_clk) disable iff (rst_link)
      state_r == ewt_pkg::ST_ACK |-> oe_r) else $error("ack not driven");
   chk_cs_nack: assert property (@(posedge link_clk) disable iff (rst_link)
      byte_done && state_r == ewt_pkg::ST_DEV && !start && !stop && dw.cs != cs_s
      |=> state_r == ewt_pkg::ST_IDLE && !oe_r) else $error("acked wrong chip select");
   chk_busy_nack: assert property (@(posedge link_clk) disable iff (rst_link)
      byte_done && state_r == ewt_pkg::ST_DEV && pend_r |=> !oe_r)
      else $error("acked while busy");
   chk_wp_nack: assert property (@(posedge link_clk) disable iff (rst_link)
      byte_done && state_r == ewt_pkg::ST_DEV && wp_prog_r && dw.nib == ewt_pkg::NIB_WP
      |=> !oe_r) else $error("acked protect word after lock");
   chk_page_wrap: assert property (@(posedge link_clk) disable iff (rst_link)
      mem_we |=> ptr_r[7:4] == $past(ptr_r[7:4]) && ptr_r[3:0] == $past(ptr_r[3:0]) + 4'h1)
      else $error("page address did not wrap");
   chk_ext_ro: assert property (@(posedge link_clk) disable iff (rst_link)
      byte_done && state_r == ewt_pkg::ST_WDAT && ext_r && !start && !stop
      |=> state_r == ewt_pkg::ST_IDLE && !oe_r) else $error("extended block write acked");
   chk_wr_start: assert property (@(posedge clock) disable iff (rst)
      $rose(busy_r) |-> busy_r[*8]) else $error("write cycle ended early");
   chk_wr_end: assert property (@(posedge clock) disable iff (rst)
      busy_r && wcnt_r == WR_LAST |=> !busy_r) else $error("write cycle overran");
   chk_id_prefix: assert property (@(posedge clock) disable iff (rst)
      ext_byte(EUI64 ? ewt_pkg::EUI64_BASE : ewt_pkg::EUI48_BASE) == ORG_PREFIX[23:16])
      else $error("id prefix misplaced");
   chk_id_rsv: assert property (@(posedge clock) disable iff (rst)
      {ext_byte(8'h9b), ext_byte(8'h9c)} < ewt_pkg::EXT_RSV_LO || !EUI64)
      else $error("reserved extension value");

   cov_read: cover property (@(posedge link_clk) disable iff (rst_link)
      state_r == ewt_pkg::ST_RACK ##1 state_r == ewt_pkg::ST_RD);
   cov_write: cover property (@(posedge link_clk) disable iff (rst_link)
      mem_we ##[1:1000] stop);
   cov_lock: cover property (@(posedge link_clk) disable iff (rst_link) $rose(wp_prog_r));
   cov_poll: cover property (@(posedge link_clk) disable iff (rst_link)
      byte_done && state_r == ewt_pkg::ST_DEV && pend_r);

endmodule : ewt_eeprom_two_wire_target

/* tb/ewt_host_model.sv */
// bus host model: drives scl and sda, reports acks and read bytes
`timescale 1ns/100ps
module ewt_host_model (
   // link timing and resolved wire
   input wire logic link_clk,
   input wire logic sda_wire,
   // bus drive, high means released to the pull-up
   output logic scl,
   output logic sda_drv,
   // observed ack bit or read byte
   output logic res_valid,
   output logic [7:0] res_val
);
   // idle bus: both lines released
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      res_valid = 1'b0;
      res_val = 8'h00;
   end
   ////////////////////////////////////////////////////////////////
   // phases of 8 link cycles keep the target's filters satisfied
   task automatic tick(input int n);
      repeat (n) @(posedge link_clk);
   endtask : tick
   // one clock pulse; data moves only while scl is low
   task automatic pulse(input logic b, output logic s);
      tick(2);
      sda_drv <= b;
      tick(6);
      scl <= 1'b1;
      tick(4);
      s = sda_wire;
      tick(4);
      scl <= 1'b0;
   endtask : pulse
   task automatic report(input logic [7:0] v);
      res_val <= v;
      res_valid <= 1'b1;
      tick(1);
      res_valid <= 1'b0;
   endtask : report
   // start before every command: data falls with scl high
   task automatic start();
      tick(2);
      sda_drv <= 1'b1;
      tick(6);
      scl <= 1'b1;
      tick(8);
      sda_drv <= 1'b0;
      tick(8);
      scl <= 1'b0;
   endtask : start
   // stop: data rises with scl high, bus left released
   task automatic stop();
      tick(2);
      sda_drv <= 1'b0;
      tick(6);
      scl <= 1'b1;
      tick(8);
      sda_drv <= 1'b1;
      tick(8);
   endtask : stop
   // eight bits msb first, then released for the ninth clock
   task automatic put(input logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(v[i], s);
      pulse(1'b1, s);
      report({7'h00, s});
   endtask : put
   // eight bits from the target, then ack low or nack high
   task automatic get(input logic last);
      logic [7:0] v;
      logic s;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b1, s);
         v[i] = s;
      end
      pulse(last, s);
      report(v);
   endtask : get
   // bus recovery: start, nine clocks, start, stop
   task automatic recover();
      logic s;
      start();
      repeat (9) pulse(1'b1, s);
      start();
      stop();
   endtask : recover
endmodule : ewt_host_model

/* tb/testbench.sv */
// self-checking bench for the two-wire eeprom target
`timescale 1ns/100ps
module testbench;
   localparam logic [127:0] SN = {4{32'h8421_c3e7}};
   localparam logic [23:0] OP = 24'h5a_6b7c; // arbitrary prefix value
   localparam logic [23:0] EI = 24'h13_5724;
   localparam logic [255:0] IMG = {SN, {10{8'hff}}, OP, EI};
   localparam logic [3:0] NA = ewt_pkg::NIB_ARRAY;
   localparam logic [3:0] NE = ewt_pkg::NIB_EXT;
   logic clock, rst, link_clk, scl, sda_o, sda_oe, standby, write_busy;
   logic sda_drv, sda_wire, res_valid;
   logic [7:0] res_val, pg;
   logic [7:0] dat[3];
   logic [2:0] cs;
   logic [15:0] eq[$];
   string nq[$];
   int fails, checks_done, cyc, seed, bcnt;
   // open-drain wire with pull-up
   assign sda_wire = sda_drv & ~(sda_oe & ~sda_o);
   ewt_eeprom_two_wire_target #(.WR_CYCLES(2000), .SERIAL_NUM(SN), .ORG_PREFIX(OP),
      .EXT_ID_48(EI), .EUI64(1'b0)) dut (.clock(clock), .rst(rst), .link_clk(link_clk),
      .scl(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
      .chip_select_pin_2(cs[2]), .chip_select_pin_1(cs[1]), .chip_select_pin_0(cs[0]),
      .standby(standby), .write_busy(write_busy));
   ewt_host_model host (.link_clk(link_clk), .sda_wire(sda_wire), .scl(scl),
      .sda_drv(sda_drv), .res_valid(res_valid), .res_val(res_val));
   ////////////////////////////////////////////////////////////////
   // clocks: link clock offset so the two never line up
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end
   // hang guard and busy-length counter
   always @(posedge clock) begin
      cyc = cyc + 1;
      // run length of the current busy stretch, cleared while idle
      if (write_busy === 1'b1) bcnt = bcnt + 1;
      else bcnt = 0;
      if (cyc == 80000) begin
         fails = fails + 1;
         close_out();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
      checks_done = checks_done + 1;
      if (v !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, v);
         fails = fails + 1;
      end
   endtask : chk
   task automatic close_out();
      if (eq.size() != 0) fails = fails + 1;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   // watcher: each reported result against the oldest note
   always @(posedge link_clk) begin
      if (res_valid === 1'b1) begin
         if (eq.size() == 0) chk("unexpected", 16'h0000, 16'hffff);
         else chk(nq.pop_front(), eq.pop_front(), {8'h00, res_val});
      end
   end
   ////////////////////////////////////////////////////////////////
   // a byte out with the expected ack: low wire means ack
   task automatic wr(input logic [7:0] v, input logic a);
      nq.push_back("ack");
      eq.push_back({15'h0000, ~a});
      host.put(v);
   endtask : wr
   task automatic rd(input logic [7:0] e, input logic last);
      nq.push_back("rdata");
      eq.push_back({8'h00, e});
      host.get(last);
   endtask : rd
   // dummy write loading the pointer, then restart for reading
   task automatic setp(input logic [3:0] nib, input logic [7:0] a);
      host.start();
      wr({nib, cs, 1'b0}, 1'b1);
      wr(a, 1'b1);
      host.start();
      wr({nib, cs, 1'b1}, 1'b1);
   endtask : setp
   // write cycle from stop: exact length, optional poll, standby after
   task automatic wait_done(input logic poll);
      int k;
      // busy may already run when the stop task returns; the hang guard
      // keeps the stretch length, so nothing is cleared here
      for (k = 0; k < 3000 && write_busy !== 1'b1; k++) @(negedge clock);
      chk("busy", 16'h0001, {15'h0000, write_busy});
      if (poll) begin
         host.start();
         wr({NA, cs, 1'b0}, 1'b0);
         host.stop();
      end
      for (k = 0; k < 3000 && write_busy === 1'b1; k++) @(negedge clock);
      chk("busy_len", 16'd2000, bcnt[15:0]);
      for (k = 0; k < 300 && standby !== 1'b1; k++) @(negedge clock);
      chk("standby", 16'h0001, {15'h0000, standby});
   endtask : wait_done
   ////////////////////////////////////////////////////////////////
   // main sequence; ten clocks of reset still span three link edges
   initial begin
      logic [7:0] bad[3];
      rst = 1'b1;
      cyc = 0;
      bcnt = 0;
      fails = 0;
      checks_done = 0;
      seed = 52;
      cs = $random(seed);
      pg = $random(seed);
      pg = {1'b0, pg[6:4], 4'he};
      for (int i = 0; i < 3; i++) dat[i] = $random(seed);
      bad = '{{4'h5, cs, 1'b0}, {NA, ~cs, 1'b0}, {ewt_pkg::NIB_WP, cs, 1'b1}};
      repeat (10) @(negedge clock);
      rst = 1'b0;
      repeat (20) @(negedge clock);
      chk("standby", 16'h0001, {15'h0000, standby});
      chk("sda_oe", 16'h0000, {15'h0000, sda_oe});
      // foreign nibble, wrong selects, protect word with read bit
      for (int i = 0; i < 3; i++) begin
         host.start();
         wr(bad[i], 1'b0);
      end
      host.stop();
      // page write crossing the page end, polled while busy
      host.start();
      wr({NA, cs, 1'b0}, 1'b1);
      wr(pg, 1'b1);
      for (int i = 0; i < 3; i++) wr(dat[i], 1'b1);
      host.stop();
      wait_done(1'b1);
      // interrupted transfer, then recovery sequence
      host.start();
      wr({NA, cs, 1'b0}, 1'b1);
      host.recover();
      setp(NA, pg);
      rd(dat[0], 1'b0);
      rd(dat[1], 1'b1);
      host.stop();
      setp(NA, {pg[7:4], 4'h0});
      rd(dat[2], 1'b1);
      host.stop();
      // extended block: data write refused, then full read
      host.start();
      wr({NE, cs, 1'b0}, 1'b1);
      wr(ewt_pkg::SERIAL_BASE, 1'b1);
      wr(8'h00, 1'b0);
      setp(NE, ewt_pkg::SERIAL_BASE);
      for (int i = 0; i < 32; i++) rd(IMG[255 - 8 * i -: 8], i == 31);
      host.stop();
      // protect lock, then protect word and low-half write refused
      host.start();
      wr({ewt_pkg::NIB_WP, cs, 1'b0}, 1'b1);
      wr(8'h00, 1'b1);
      wr(8'h00, 1'b1);
      host.stop();
      wait_done(1'b0);
      host.start();
      wr({ewt_pkg::NIB_WP, cs, 1'b0}, 1'b0);
      host.start();
      wr({NA, cs, 1'b0}, 1'b1);
      wr(pg, 1'b1);
      wr(~dat[0], 1'b1);
      host.stop();
      wait_done(1'b0);
      setp(NA, pg);
      rd(dat[0], 1'b1);
      host.stop();
      repeat (200) @(negedge clock);
      chk("standby", 16'h0001, {15'h0000, standby});
      close_out();
   end
endmodule : testbench
